//--- logic/csc_ctrl.sv
// Source detection, power state and status pin control of the charger
`timescale 1ns/100ps
module csc_ctrl #(
    parameter int DET_WAIT_CYC = csc_pkg::DET_WAIT_CYC,
    parameter int DET_DISC_CYC = csc_pkg::DET_DISC_CYC,
    parameter int CHG_DEGL_CYC = csc_pkg::CHG_DEGL_CYC,
    parameter int OVP_BLK_CYC = csc_pkg::OVP_BLK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // D+/D- sensing
    input wire logic dp_high,
    input wire logic dm_high,
    input wire logic dpdm_short,
    input wire logic dpdm_pulldown,
    output logic dpdm_connect,
    // Comparator flags
    input wire logic vin_above_undervoltage_lockout,
    input wire logic vin_above_sleep,
    input wire logic vin_over_ovp,
    input wire logic out_below_rch,
    input wire logic taper_done,
    input wire logic fast_current_set_short,
    input wire logic out_ge_80ma,
    input wire logic batt_below_lowv,
    input wire logic batt_inserted,
    // Host pins
    input wire logic thermistor_low,
    input wire logic term_timer_disable_mode,
    input wire logic lim_sel_low,
    input wire logic lim_sel_high,
    // Charger control
    output csc_pkg::csc_lim_t lim_mode,
    output logic charge_en,
    output logic precharge,
    output logic timer_run,
    output logic timer_clear,
    output logic [5:0] term_pct,
    output logic [6:0] pre_pct,
    output logic latched_off,
    // Open-drain status pins
    output logic power_good_n_o,
    output logic power_good_n_oe,
    output logic charge_status_n_o,
    output logic charge_status_n_oe
);
    import csc_pkg::*;

    function automatic csc_lim_t pin_mode(input logic lo, input logic hi);
        if (lo) begin
            return LIM_FAST_CURRENT_SET;
        end else if (hi) begin
            return LIM_500;
        end
        return LIM_100;
    endfunction : pin_mode

    logic [FLAG_W-1:0] flags;
    logic s_dp, s_dm, s_short, s_pd, s_undervoltage_lockout, s_sleep, s_ovp, s_rch;
    logic s_taper, s_fast_current_set, s_80ma, s_lowv, s_ins, s_ts, s_term_timer_disable_mode;
    logic s_lo, s_hi;
    csc_pwr_t pwr_reg;
    csc_pwr_t pwr_next;
    csc_det_t det_reg;
    logic wait_done, run_done, filt_done, ovp_done, degl_done;
    logic adaptor_reg, host_reg, fault_reg, powered_reg;
    csc_lim_t ref_reg;
    logic first_reg, term_reg, ovp_seen_reg;
    logic ts_q, term_timer_disable_mode_q, rch_q, lowv_q, ins_q;
    logic pg_apply, ts_release, term_timer_disable_mode_exit, rch_drop, pre_entry, new_cycle;
    logic [31:0] cfg_reg;
    logic [5:0] term_clamp;
    logic access;

    // Comparator and pin flags all pass two flops
    csc_sync #(.W(FLAG_W)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .d({dp_high, dm_high, dpdm_short, dpdm_pulldown, vin_above_undervoltage_lockout,
            vin_above_sleep, vin_over_ovp, out_below_rch, taper_done,
            fast_current_set_short, out_ge_80ma, batt_below_lowv, batt_inserted,
            thermistor_low, term_timer_disable_mode, lim_sel_low,
            lim_sel_high}),
        .q(flags)
    );
    assign {s_dp, s_dm, s_short, s_pd, s_undervoltage_lockout, s_sleep, s_ovp, s_rch,
            s_taper, s_fast_current_set, s_80ma, s_lowv, s_ins, s_ts, s_term_timer_disable_mode,
            s_lo, s_hi} = flags;

    csc_timer #(.W(TMR_W)) u_wait (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(det_reg == DET_WAIT && pwr_reg != PWR_DOWN),
        .limit(TMR_W'(DET_WAIT_CYC)),
        .done(wait_done)
    );
    csc_timer #(.W(TMR_W)) u_disc (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(det_reg == DET_RUN),
        .limit(TMR_W'(DET_DISC_CYC - 2)),
        .done(run_done)
    );
    csc_timer #(.W(TMR_W)) u_filt (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(det_reg == DET_DONE && !host_reg
            && pin_mode(s_lo, s_hi) != ref_reg),
        .limit(TMR_W'(LIM_FILT_CYC)),
        .done(filt_done)
    );
    csc_timer #(.W(TMR_W)) u_ovp (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(s_ovp && (pwr_reg == PWR_ACT || pwr_reg == PWR_SLP)),
        .limit(TMR_W'(OVP_BLK_CYC)),
        .done(ovp_done)
    );
    csc_timer #(.W(TMR_W)) u_degl (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .run(ovp_seen_reg && pwr_reg == PWR_ACT),
        .limit(TMR_W'(CHG_DEGL_CYC)),
        .done(degl_done)
    );

    // Power state; the short fault outranks everything but undervoltage lockout
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_FLT: pwr_next = s_undervoltage_lockout ? PWR_FLT : PWR_DOWN;
            PWR_OVP: begin
                if (!s_undervoltage_lockout) begin
                    pwr_next = PWR_DOWN;
                end else if (!s_ovp) begin
                    pwr_next = s_sleep ? PWR_ACT : PWR_SLP;
                end
            end
            default: begin
                if (!s_undervoltage_lockout) begin
                    pwr_next = PWR_DOWN;
                end else if (pwr_reg == PWR_ACT && s_fast_current_set && s_80ma) begin
                    pwr_next = PWR_FLT;
                end else if (ovp_done) begin
                    pwr_next = PWR_OVP;
                end else if (!s_sleep) begin
                    pwr_next = PWR_SLP;
                end else begin
                    pwr_next = PWR_ACT;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pwr_reg <= PWR_DOWN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // Source detection sequence
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pwr_reg == PWR_DOWN) begin
            det_reg <= DET_WAIT;
            adaptor_reg <= 1'b0;
        end else begin
            unique case (det_reg)
                DET_WAIT: begin
                    if (s_dp || s_dm || wait_done) begin
                        det_reg <= DET_RUN;
                    end
                end
                DET_RUN: begin
                    if (run_done) begin
                        det_reg <= DET_DONE;
                        adaptor_reg <= s_short && !s_pd;
                    end
                end
                DET_DONE: det_reg <= DET_DONE;
                default: det_reg <= DET_WAIT;
            endcase
        end
    end

    // Limit latch and handover to the select pin
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pwr_reg == PWR_DOWN) begin
            host_reg <= 1'b0;
            ref_reg <= LIM_100;
            lim_mode <= LIM_100;
        end else begin
            if (det_reg == DET_RUN && run_done) begin
                ref_reg <= pin_mode(s_lo, s_hi);
            end
            if (filt_done) begin
                host_reg <= 1'b1;
            end
            if (host_reg) begin
                lim_mode <= pin_mode(s_lo, s_hi);
            end else if (det_reg == DET_DONE && adaptor_reg) begin
                lim_mode <= LIM_FAST_CURRENT_SET;
            end else begin
                lim_mode <= LIM_100;
            end
        end
    end

    // Events that start a charge cycle, and precharge entry for the first-charge flag
    assign pg_apply = pwr_reg == PWR_ACT && !powered_reg;
    assign ts_release = ts_q && !s_ts;
    assign term_timer_disable_mode_exit = term_timer_disable_mode_q && !s_term_timer_disable_mode;
    assign rch_drop = term_reg && s_rch && !rch_q;
    assign pre_entry = s_lowv && !lowv_q;
    assign new_cycle = pg_apply || ts_release || term_timer_disable_mode_exit || rch_drop
        || (s_ins && !ins_q);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ts_q <= 1'b0;
            term_timer_disable_mode_q <= 1'b0;
            rch_q <= 1'b0;
            lowv_q <= 1'b0;
            ins_q <= 1'b0;
            powered_reg <= 1'b0;
        end else begin
            ts_q <= s_ts;
            term_timer_disable_mode_q <= s_term_timer_disable_mode;
            rch_q <= s_rch;
            lowv_q <= s_lowv;
            ins_q <= s_ins;
            powered_reg <= pwr_reg != PWR_DOWN && (powered_reg
                || pwr_reg == PWR_ACT);
        end
    end

    // First-charge and termination flags; a set wins over a clear for first_reg, a clear wins for term_reg
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pwr_reg == PWR_DOWN) begin
            first_reg <= 1'b0;
            term_reg <= 1'b0;
        end else begin
            if (pg_apply || ts_release || pre_entry) begin
                first_reg <= 1'b1;
            end else if (charge_en && s_taper && !s_lowv) begin
                first_reg <= 1'b0;
            end
            if (new_cycle) begin
                term_reg <= 1'b0;
            end else if (charge_en && s_taper && !s_term_timer_disable_mode && !s_lowv) begin
                term_reg <= 1'b1;
            end
        end
    end

    // Status pin held off for a while after overvoltage ends
    always_ff @(posedge clk_sys) begin
        if (!reset_n || pwr_reg == PWR_DOWN) begin
            ovp_seen_reg <= 1'b0;
        end else if (pwr_reg == PWR_OVP) begin
            ovp_seen_reg <= 1'b1;
        end else if (degl_done) begin
            ovp_seen_reg <= 1'b0;
        end
    end

    // Charger control and pin outputs
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            charge_en <= 1'b0;
            precharge <= 1'b0;
            timer_run <= 1'b0;
            timer_clear <= 1'b0;
            latched_off <= 1'b0;
            dpdm_connect <= 1'b0;
            power_good_n_o <= 1'b0;
            power_good_n_oe <= 1'b0;
            charge_status_n_o <= 1'b0;
            charge_status_n_oe <= 1'b0;
        end else begin
            // Pause; the safety timer keeps its count, and is cleared when the thermistor input releases
            charge_en <= pwr_reg == PWR_ACT && !s_ts && !term_reg;
            timer_run <= pwr_reg == PWR_ACT && !s_ts && !term_reg;
            timer_clear <= pg_apply || ts_release || term_timer_disable_mode_exit;
            precharge <= s_lowv;
            latched_off <= pwr_reg == PWR_FLT;
            dpdm_connect <= pwr_reg != PWR_DOWN && det_reg != DET_DONE;
            power_good_n_o <= 1'b0;
            power_good_n_oe <= pwr_reg == PWR_ACT;
            charge_status_n_o <= 1'b0;
            charge_status_n_oe <= pwr_reg == PWR_ACT && first_reg
                && !ovp_seen_reg;
        end
    end

    // Termination setting: clamped field, or defaults when floating
    assign term_clamp = cfg_reg[5:0] < TERM_MIN ? TERM_MIN
        : cfg_reg[5:0] > TERM_MAX ? TERM_MAX : cfg_reg[5:0];

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            term_pct <= TERM_DEF;
            pre_pct <= {TERM_DEF, 1'b0};
        end else if (cfg_reg[CFG_FLOAT_BIT]) begin
            term_pct <= TERM_DEF;
            pre_pct <= {TERM_DEF, 1'b0};
        end else begin
            term_pct <= term_clamp;
            pre_pct <= {term_clamp, 1'b0};
        end
    end

    // APB slave, one wait state; a write lands as pready is sampled high
    assign access = psel && penable && !pready;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_reg <= CFG_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access && paddr != ADDR_CFG && paddr != ADDR_STAT;
            prdata <= 32'h00000000;
            if (access && !pwrite && paddr == ADDR_CFG) begin
                prdata <= {23'h000000, cfg_reg[8:0]};
            end else if (access && !pwrite && paddr == ADDR_STAT) begin
                prdata <= {16'h0000, fault_reg, term_reg, first_reg,
                    charge_en, 1'b0, ref_reg, lim_mode, host_reg,
                    adaptor_reg, det_reg, pwr_reg};
            end
            if (psel && penable && pready && pwrite
                && paddr == ADDR_CFG) begin
                cfg_reg <= {23'h000000, pwdata[8:0]};
            end
        end
    end

    assign fault_reg = pwr_reg == PWR_FLT;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_fault_entry: assert property (pwr_reg == PWR_ACT
        && s_undervoltage_lockout && s_fast_current_set && s_80ma |=> pwr_reg == PWR_FLT)
        else $error("short fault not latched");
    a_fault_hold: assert property (pwr_reg == PWR_FLT && s_undervoltage_lockout
        |=> pwr_reg == PWR_FLT ##1 !charge_en && !power_good_n_oe)
        else $error("fault released or charging");
    a_sleep_pause: assert property (pwr_reg == PWR_SLP
        |=> !timer_run && !power_good_n_oe && !charge_status_n_oe)
        else $error("sleep left outputs active");
    a_pg_window: assert property ($rose(power_good_n_oe)
        |-> $past(pwr_reg) == PWR_ACT)
        else $error("power good outside window");
    a_lim_start: assert property (det_reg != DET_DONE && !host_reg
        |=> lim_mode == LIM_100)
        else $error("limit not 100mA before detection");
    a_disc_time: assert property (det_reg == DET_RUN && run_done
        && pwr_reg != PWR_DOWN
        |=> det_reg == DET_DONE ##1 !dpdm_connect)
        else $error("detection switches not released");
    a_chg_degl: assert property (ovp_seen_reg
        |=> !charge_status_n_oe)
        else $error("status pin before deglitch");
    a_pre_twice: assert property (pre_pct == {term_pct, 1'b0}
        && term_pct >= TERM_MIN && term_pct <= TERM_MAX)
        else $error("precharge not twice termination");
    a_ts_stop: assert property (s_ts |=> !charge_en && !timer_run)
        else $error("charging while disabled");
    a_term_done: assert property (charge_en && s_taper && !s_lowv
        && !pg_apply && !ts_release && !pre_entry |=> !first_reg)
        else $error("first charge not ended");
    a_precharge: assert property (precharge == $past(s_lowv))
        else $error("precharge does not follow battery");

    c_adaptor: cover property (det_reg == DET_DONE && adaptor_reg
        && lim_mode == LIM_FAST_CURRENT_SET);
    c_host: cover property ($rose(host_reg));
    c_ovp: cover property (pwr_reg == PWR_OVP ##1 pwr_reg == PWR_ACT);
    c_fault: cover property ($rose(latched_off));
endmodule : csc_ctrl

//--- logic/csc_pkg.sv
// Constants and types for the charger source and status control block
package csc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int DET_WAIT_MS = 500;
    localparam int DET_DISC_MS = 100;
    localparam int CHG_DEGL_MS = 25;
    localparam int OVP_BLK_US = 100;
    localparam int LIM_FILT_NS = 5000;
    localparam int DET_WAIT_CYC = DET_WAIT_MS * CYC_PER_MS;
    localparam int DET_DISC_CYC = DET_DISC_MS * CYC_PER_MS;
    localparam int CHG_DEGL_CYC = CHG_DEGL_MS * CYC_PER_MS;
    localparam int OVP_BLK_CYC = OVP_BLK_US * (CLK_HZ / 1_000_000);
    localparam int LIM_FILT_CYC =
        (LIM_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TMR_W = 27;
    localparam int FLAG_W = 17;
    localparam logic [11:0] ADDR_CFG = 12'h000;
    localparam logic [11:0] ADDR_STAT = 12'h004;
    localparam logic [5:0] TERM_DEF = 6'h0A;
    localparam logic [5:0] TERM_MIN = 6'h05;
    localparam logic [5:0] TERM_MAX = 6'h32;
    localparam int CFG_FLOAT_BIT = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000010A;
    typedef enum logic [1:0] {
        LIM_100 = 2'h0,
        LIM_500 = 2'h1,
        LIM_FAST_CURRENT_SET = 2'h2
    } csc_lim_t;
    typedef enum logic [2:0] {
        PWR_DOWN = 3'h0,
        PWR_SLP = 3'h1,
        PWR_ACT = 3'h3,
        PWR_OVP = 3'h2,
        PWR_FLT = 3'h6
    } csc_pwr_t;
    typedef enum logic [1:0] {
        DET_WAIT = 2'h0,
        DET_RUN = 2'h1,
        DET_DONE = 2'h3
    } csc_det_t;
endpackage : csc_pkg

//--- logic/csc_sync.sv
// Two-stage synchroniser for a vector of asynchronous flags
`timescale 1ns/100ps
module csc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Flags
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : csc_sync

//--- logic/csc_timer.sv
// Elapsed-time counter that flags when a run has lasted limit cycles
`timescale 1ns/100ps
module csc_timer #(
    parameter int W = 27
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    input wire logic run,
    input wire logic [W-1:0] limit,
    output logic done
);
    logic [W-1:0] cnt_reg;

    // Saturates, so done stays up for as long as run holds
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !run) begin
            cnt_reg <= '0;
        end else if (cnt_reg != limit) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign done = run && (cnt_reg == limit);
endmodule : csc_timer

//--- tb/csc_src_model.sv
// Source model: wall adaptor or USB host as seen on D+/D-
`timescale 1ns/100ps
module csc_src_model #(
    parameter int ONLINE_DLY = 30
) (
    // Clock
    input wire logic clk_sys,
    // Source kind: 0 none, 1 adaptor, 2 USB host
    input wire logic [1:0] mode,
    // D+/D- sensing
    input wire logic dpdm_connect,
    output logic dp_high,
    output logic dm_high,
    output logic dpdm_short,
    output logic dpdm_pulldown
);
    int cnt = 0;
    logic wob = 1'b0;
    always_ff @(posedge clk_sys) begin
        cnt <= (mode == 2'h2) ? cnt + 1 : 0;
        wob <= ~wob;
    end
    // Transceiver pulls D+ up once on line; an adaptor never does
    assign dp_high = (mode == 2'h2) && (cnt >= ONLINE_DLY);
    assign dm_high = 1'b0;
    // Switches open: comparators read nothing useful, so no stale value
    assign dpdm_short = dpdm_connect ? (mode == 2'h1) : wob;
    assign dpdm_pulldown = dpdm_connect ? (mode == 2'h2) : ~wob;
endmodule : csc_src_model

//--- tb/test_charger_source_status_ctrl.sv
// Bench for the charger source and status control block
`timescale 1ns/100ps
module test_charger_source_status_ctrl;
    import csc_pkg::*;
    localparam int DISC_C = 50;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, dp_high, dm_high, dpdm_short, dpdm_pulldown;
    logic dpdm_connect, vin_above_undervoltage_lockout = 0, vin_above_sleep = 0;
    logic vin_over_ovp = 0, out_below_rch = 0, taper_done = 0;
    logic fast_current_set_short = 0, out_ge_80ma = 0, batt_below_lowv = 0;
    logic batt_inserted = 0, thermistor_low = 0;
    logic term_timer_disable_mode = 0, lim_sel_low = 0, lim_sel_high = 0;
    logic [1:0] mode = 2'h0;
    csc_lim_t lim_mode;
    logic charge_en, precharge, timer_run, timer_clear, latched_off;
    logic [5:0] term_pct;
    logic [6:0] pre_pct;
    logic pg_o, pg_oe, cs_o, cs_oe, er;
    logic [31:0] rd;
    int bad_count = 0;
    int checks = 0;
    int clr_count = 0;
    int i;
    csc_lim_t lim_tab [3] = '{LIM_500, LIM_100, LIM_FAST_CURRENT_SET};

    csc_ctrl #(.DET_WAIT_CYC(200), .DET_DISC_CYC(DISC_C),
        .CHG_DEGL_CYC(40), .OVP_BLK_CYC(20)) dut_u (.clk_sys, .reset_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dp_high, .dm_high, .dpdm_short, .dpdm_pulldown,
        .dpdm_connect, .vin_above_undervoltage_lockout, .vin_above_sleep, .vin_over_ovp,
        .out_below_rch, .taper_done, .fast_current_set_short, .out_ge_80ma,
        .batt_below_lowv, .batt_inserted, .thermistor_low,
        .term_timer_disable_mode, .lim_sel_low, .lim_sel_high, .lim_mode,
        .charge_en, .precharge, .timer_run, .timer_clear, .term_pct,
        .pre_pct, .latched_off, .power_good_n_o(pg_o),
        .power_good_n_oe(pg_oe), .charge_status_n_o(cs_o),
        .charge_status_n_oe(cs_oe));

    csc_src_model src_u (.clk_sys, .mode, .dpdm_connect, .dp_high,
        .dm_high, .dpdm_short, .dpdm_pulldown);

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    // Timer clear is a one-cycle pulse, so count it as it passes
    always @(posedge clk_sys) begin
        if (timer_clear === 1'b1) clr_count++;
    end

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks++;
        if (seen !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    // Holds the request until pready is seen at an edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        do begin
            tick(1);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask : apb

    task stop_test;
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        tick(20000);
        bad_count++;
        stop_test;
    end

    initial begin
        tick(8);
        reset_n <= 1'b1;
        tick(2);
        chk("lim_rst", lim_mode, LIM_100);
        chk("term_rst", term_pct, 32'h0A);
        chk("pre_rst", pre_pct, 32'h14);
        chk("pg_down", pg_oe, 32'h0);
        mode <= 2'h1;
        vin_above_undervoltage_lockout <= 1'b1;
        vin_above_sleep <= 1'b1;
        tick(150);
        chk("lim_early", lim_mode, LIM_100);
        chk("pg_on", pg_oe, 32'h1);
        chk("od_low", {pg_o, cs_o}, 32'h0);
        for (i = 0; i < 150 && lim_mode !== LIM_FAST_CURRENT_SET; i++) tick(1);
        tick(8);
        chk("lim_adp", lim_mode, LIM_FAST_CURRENT_SET);
        chk("cs_first", cs_oe, 32'h1);
        batt_below_lowv <= 1'b1;
        tick(8);
        chk("pre_on", precharge, 32'h1);
        batt_below_lowv <= 1'b0;
        tick(8);
        chk("pre_off", precharge, 32'h0);
        vin_above_sleep <= 1'b0;
        tick(8);
        chk("slp_pg", {pg_oe, cs_oe, charge_en, timer_run}, 32'h0);
        vin_above_sleep <= 1'b1;
        tick(8);
        chk("wake", {pg_oe, cs_oe, charge_en, timer_run}, 32'hF);
        vin_over_ovp <= 1'b1;
        tick(12);
        chk("ovp_blk", charge_en, 32'h1);
        tick(20);
        chk("ovp", {pg_oe, cs_oe, charge_en, timer_run}, 32'h0);
        vin_over_ovp <= 1'b0;
        tick(8);
        chk("ovp_clr", {pg_oe, cs_oe, charge_en}, 32'h5);
        tick(45);
        chk("ovp_cs", cs_oe, 32'h1);
        lim_sel_high <= 1'b1;
        tick(100);
        chk("lim_latch", lim_mode, LIM_FAST_CURRENT_SET);
        for (i = 0; i < 3; i++) begin
            lim_sel_high <= (i == 0);
            lim_sel_low <= (i == 2);
            tick(700);
            chk("lim_pin", lim_mode, lim_tab[i]);
        end
        taper_done <= 1'b1;
        tick(8);
        chk("cs_done", cs_oe, 32'h0);
        taper_done <= 1'b0;
        out_below_rch <= 1'b1;
        tick(8);
        chk("rch_chg", charge_en, 32'h1);
        chk("rch_cs", cs_oe, 32'h0);
        out_below_rch <= 1'b0;
        i = clr_count;
        term_timer_disable_mode <= 1'b1;
        tick(8);
        term_timer_disable_mode <= 1'b0;
        tick(8);
        chk("term_timer_disable_mode_cs", cs_oe, 32'h0);
        chk("term_timer_disable_mode_clr", clr_count - i, 32'h1);
        thermistor_low <= 1'b1;
        tick(8);
        chk("ts_off", charge_en, 32'h0);
        thermistor_low <= 1'b0;
        tick(8);
        chk("ts_cs", {cs_oe, charge_en}, 32'h3);
        taper_done <= 1'b1;
        tick(8);
        chk("ins_off", charge_en, 32'h0);
        taper_done <= 1'b0;
        batt_inserted <= 1'b1;
        tick(8);
        chk("ins_chg", {cs_oe, charge_en}, 32'h1);
        batt_inserted <= 1'b0;
        apb(ADDR_CFG, 1'b1, 32'h19);
        apb(ADDR_CFG, 1'b0, 32'h0);
        chk("cfg_rd", rd, 32'h19);
        chk("pct", {term_pct, pre_pct}, {6'h19, 7'h32});
        apb(ADDR_CFG, 1'b1, 32'h3C);
        tick(2);
        chk("term_max", term_pct, 32'h32);
        apb(ADDR_CFG, 1'b1, 32'h100);
        tick(2);
        chk("pct_def", {term_pct, pre_pct}, {6'h0A, 7'h14});
        apb(12'h008, 1'b0, 32'h0);
        chk("unmap", {er, rd}, {1'b1, 32'h0});
        fast_current_set_short <= 1'b1;
        tick(8);
        chk("short_lo", latched_off, 32'h0);
        out_ge_80ma <= 1'b1;
        tick(8);
        chk("latch", latched_off, 32'h1);
        chk("flt", {pg_oe, cs_oe, charge_en}, 32'h0);
        fast_current_set_short <= 1'b0;
        out_ge_80ma <= 1'b0;
        tick(8);
        chk("latch_hold", latched_off, 32'h1);
        vin_above_undervoltage_lockout <= 1'b0;
        mode <= 2'h2;
        tick(8);
        vin_above_undervoltage_lockout <= 1'b1;
        tick(8);
        chk("pwr_cyc", latched_off, 32'h0);
        for (i = 0; i < 60 && dp_high !== 1'b1; i++) tick(1);
        chk("conn", dpdm_connect, 32'h1);
        tick(DISC_C + 6);
        chk("disc", dpdm_connect, 32'h0);
        tick(20);
        chk("lim_usb", lim_mode, LIM_100);
        stop_test;
    end
endmodule : test_charger_source_status_ctrl
